// [design/rtam_top.sv]
// module: remote target address map with wishbone slave and translator
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Each of targets 2 to 6 keeps a 7-bit target address in bits 7:1.
// - Only local-side transactions whose address equals the alias match.
// - On a match the stored target address replaces the incoming one.
// - The translated transaction is sent on toward the remote side.
// - A zero target address blocks all access to that target.
// - Each alias holds 7 bits and, once non-zero, is accepted locally.
module rtam_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rtam_pkg::RTAM_WB_ADR_W+1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // local control-bus request
  input wire logic req_valid,
  input wire logic req_local,
  input wire logic [6:0] req_addr,
  // toward the control channel
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic [2:0] fwd_target,
  output logic req_blocked,
  output logic req_nomatch
);
  import rtam_pkg::*;

  // ****************************************
  // entry storage
  // ****************************************
  logic [6:0] target_reg [RTAM_NUM_TARGETS];
  logic [6:0] alias_reg [RTAM_NUM_TARGETS];
  logic [RTAM_NUM_TARGETS-1:0] hit_vec;
  logic [RTAM_NUM_TARGETS-1:0] blk_vec;

  // ****************************************
  // bus decode
  // ****************************************
  wire [RTAM_WB_ADR_W-1:0] idx;
  wire bus_req;
  wire wr_lane0;
  wire tgt_sel;
  wire als_sel;
  wire sts_sel;
  wire [2:0] tgt_num;
  wire [2:0] als_num;
  assign idx = wb_adr_i[RTAM_WB_ADR_W+1:RTAM_BYTE_SHIFT];
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
  assign tgt_sel = (idx >= RTAM_IDX_TARGET_2) && (idx <= RTAM_IDX_TARGET_6);
  assign als_sel = (idx >= RTAM_IDX_ALIAS_2) && (idx <= RTAM_IDX_ALIAS_6);
  assign sts_sel = (idx == RTAM_IDX_STATUS);
  assign tgt_num = 3'(idx - RTAM_IDX_TARGET_2);
  assign als_num = 3'(idx - RTAM_IDX_ALIAS_2);

  // read data, upper bits as zero; reserved bit 0 zero except in the status word, where it is a target number bit
  logic [31:0] rd_data;
  logic [7:0] status_reg;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (tgt_sel) begin
      rd_data[RTAM_FIELD_MSB:RTAM_FIELD_LSB] = target_reg[tgt_num];
    end else if (als_sel) begin
      rd_data[RTAM_FIELD_MSB:RTAM_FIELD_LSB] = alias_reg[als_num];
    end else if (sts_sel) begin
      rd_data[RTAM_REG_W-1:0] = status_reg;
    end
  end

  // every access, mapped or not, is acked one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  // bit 0 of write data is dropped
  genvar g;
  generate
    for (g = 0; g < RTAM_NUM_TARGETS; g++) begin : g_ent
      rtam_entry_if eif ();
      assign eif.target_addr = target_reg[g];
      assign eif.alias_addr = alias_reg[g];
      assign eif.req_addr = req_addr;
      assign hit_vec[g] = eif.hit;
      assign blk_vec[g] = eif.blocked;
      rtam_entry_match u_match (
        .ent(eif.matcher)
      );
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          target_reg[g] <= RTAM_REG_RESET[RTAM_FIELD_MSB:RTAM_FIELD_LSB];
          alias_reg[g] <= RTAM_REG_RESET[RTAM_FIELD_MSB:RTAM_FIELD_LSB];
        end else if (wr_lane0) begin
          if (tgt_sel && tgt_num == 3'(g)) begin
            target_reg[g] <= wb_dat_i[RTAM_FIELD_MSB:RTAM_FIELD_LSB];
          end
          if (als_sel && als_num == 3'(g)) begin
            alias_reg[g] <= wb_dat_i[RTAM_FIELD_MSB:RTAM_FIELD_LSB];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // translation
  // ****************************************
  // lowest-numbered entry wins if two aliases collide
  logic [6:0] sel_addr;
  logic [2:0] sel_num;
  logic any_hit;
  always_comb begin
    sel_addr = RTAM_ADDR_NONE;
    sel_num = 3'h0;
    any_hit = 1'b0;
    for (int i = RTAM_NUM_TARGETS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        sel_addr = target_reg[i];
        sel_num = 3'(i + RTAM_FIRST_TARGET);
        any_hit = 1'b1;
      end
    end
  end

  wire take;
  wire fwd_next;
  wire blk_next;
  wire nom_next;
  assign take = req_valid && req_local;
  assign fwd_next = take && any_hit;
  assign blk_next = take && !any_hit && (|blk_vec);
  assign nom_next = take && !any_hit && !(|blk_vec);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid <= 1'b0;
      fwd_addr <= RTAM_ADDR_NONE;
      fwd_target <= 3'h0;
      req_blocked <= 1'b0;
      req_nomatch <= 1'b0;
      status_reg <= RTAM_REG_RESET;
    end else begin
      fwd_valid <= fwd_next;
      fwd_addr <= fwd_next ? sel_addr : RTAM_ADDR_NONE;
      fwd_target <= fwd_next ? sel_num : 3'h0;
      req_blocked <= blk_next;
      req_nomatch <= nom_next;
      if (take) begin
        status_reg <= {fwd_next, blk_next, 3'h0, sel_num};
      end
    end
  end
endmodule : rtam_top

// [shared/rtam_pkg.sv]
// package: register map, field layout and widths of the remote target map
package rtam_pkg;
  localparam int RTAM_NUM_TARGETS = 5;
  localparam int RTAM_FIRST_TARGET = 2;
  localparam int RTAM_ADDR_W = 7;
  localparam int RTAM_REG_W = 8;
  localparam int RTAM_WB_ADR_W = 8;
  // printed offsets are not multiples of four: these are indices
  localparam logic [7:0] RTAM_IDX_TARGET_2 = 8'h0A;
  localparam logic [7:0] RTAM_IDX_TARGET_3 = 8'h0B;
  localparam logic [7:0] RTAM_IDX_TARGET_4 = 8'h0C;
  localparam logic [7:0] RTAM_IDX_TARGET_5 = 8'h0D;
  localparam logic [7:0] RTAM_IDX_TARGET_6 = 8'h0E;
  // alias registers for the same targets
  localparam logic [7:0] RTAM_IDX_ALIAS_2 = 8'h12;
  localparam logic [7:0] RTAM_IDX_ALIAS_6 = 8'h16;
  // status register showing the last translation outcome
  localparam logic [7:0] RTAM_IDX_STATUS = 8'h20;
  localparam logic [7:0] RTAM_REG_RESET = 8'h00;
  localparam logic [6:0] RTAM_ADDR_NONE = 7'h00;
  localparam int RTAM_FIELD_LSB = 1;
  localparam int RTAM_FIELD_MSB = 7;
  localparam int RTAM_RESERVED_BIT_BIT = 0;
  localparam logic [1:0] RTAM_BYTE_SHIFT = 2'h2;
endpackage : rtam_pkg

// [shared/rtam_entry_if.sv]
// interface: one target entry, its alias and its match result
`timescale 1ns/1ps
interface rtam_entry_if;
  logic [6:0] target_addr;
  logic [6:0] alias_addr;
  logic [6:0] req_addr;
  logic hit;
  logic blocked;
  modport owner (output target_addr, output alias_addr, output req_addr,
    input hit, input blocked);
  modport matcher (input target_addr, input alias_addr, input req_addr,
    output hit, output blocked);
endinterface : rtam_entry_if

// [design/rtam_entry_match.sv]
// module: alias compare for one remote target entry
`timescale 1ns/1ps
module rtam_entry_match (
  // entry
  rtam_entry_if.matcher ent
);
  import rtam_pkg::*;
  wire alias_set;
  wire target_set;
  assign alias_set = (ent.alias_addr != RTAM_ADDR_NONE);
  assign target_set = (ent.target_addr != RTAM_ADDR_NONE);
  // a zero target address closes the entry entirely
  assign ent.hit = alias_set && target_set
    && (ent.req_addr == ent.alias_addr);
  assign ent.blocked = alias_set && !target_set
    && (ent.req_addr == ent.alias_addr);
endmodule : rtam_entry_match

// [test/rtam_remote.sv]
// remote serializer model: delivers forwarded transactions to targets
`timescale 1ns/1ps
module rtam_remote (
  // from the map
  input wire logic fwd_valid,
  input wire logic [6:0] fwd_addr,
  input wire logic [2:0] fwd_target,
  // delivery, combinational so the bench sees it in the forward cycle
  output logic got_valid,
  output logic [9:0] got
);
  assign got_valid = fwd_valid;
  assign got = {fwd_target, fwd_addr};
endmodule : rtam_remote

// [test/rtam_top_assertions.sv]
// checker: timing relations at the ports of the remote target map
`timescale 1ns/1ps
module rtam_checker (
  // clock, bus and request
  input wire logic clk, input wire logic reset_n,
  input wire logic wb_cyc_i, input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o, input wire logic wb_ack_o,
  input wire logic req_valid, input wire logic req_local,
  input wire logic [6:0] req_addr,
  input wire logic [9:0] wb_adr_i,
  // results
  input wire logic fwd_valid, input wire logic [6:0] fwd_addr,
  input wire logic [2:0] fwd_target,
  input wire logic req_blocked, input wire logic req_nomatch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire tk = req_valid && req_local;
  wire any = fwd_valid || req_blocked || req_nomatch;
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  // the status word uses bit 0 for the target number, so it is exempt
  reserved_bit_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0
    && ($past(wb_adr_i[9:2]) == rtam_pkg::RTAM_IDX_STATUS
    || wb_dat_o[0] == 1'b0)) else $error("reserved read bits set");
  one_answer_a: assert property (tk |=>
    $onehot({fwd_valid, req_blocked, req_nomatch})) else $error("answer");
  remote_quiet_a: assert property (!tk |=> !any)
    else $error("result without a local request");
  fwd_target_a: assert property (fwd_valid |->
    fwd_target inside {[2:6]}) else $error("target number out of range");
  zero_blocked_a: assert property (fwd_valid |-> fwd_addr != 7'h00)
    else $error("forward to a zero address");
  idle_zero_a: assert property (!fwd_valid |-> fwd_addr == 7'h00
    && fwd_target == 3'h0) else $error("forward fields not idle");
  alias_none_a: assert property (tk && req_addr == 7'h00 |=>
    req_nomatch) else $error("address zero matched");
endmodule : rtam_checker
bind rtam_top rtam_checker i_chk (.*);

// [test/remote_target_address_map_test.sv]
// testbench: register map and alias translation of the remote target map
`timescale 1ns/1ps
module remote_target_address_map_test;
  import rtam_pkg::*;
  logic clk, reset_n, cyc, stb, we, rv, rl, rd, ack, fv, blk, nom, gv;
  logic [9:0] adr, got;
  logic [3:0] sel;
  logic [31:0] di, dout;
  logic [6:0] ra, fa;
  logic [2:0] ft;
  logic [31:0] rq[$];
  logic [12:0] tq[$];
  logic [6:0] tv[2:6];
  int failures = 0, num_checks = 0, seed = 83, cyc_n = 0;
  rtam_top i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .req_valid(rv),
    .req_local(rl), .req_addr(ra), .fwd_valid(fv), .fwd_addr(fa),
    .fwd_target(ft), .req_blocked(blk), .req_nomatch(nom));
  rtam_remote i_rem (.fwd_valid(fv), .fwd_addr(fa), .fwd_target(ft),
    .got_valid(gv), .got(got));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [31:0] e, g, input string n);
    num_checks++;
    if (e !== g) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'h0}; di <= d; rd <= !w;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task xl(input logic l, input logic [6:0] a, input logic [12:0] e);
    @(posedge clk);
    rv <= 1'b1; rl <= l; ra <= a;
    if (l) tq.push_back(e);
  endtask : xl
  // results arrive a cycle after the take, so sample mid-cycle
  always @(negedge clk) begin
    if (ack && rd) check(rq.pop_front(), dout, "rdata");
    if (gv || blk || nom) check(32'(tq.pop_front()),
      32'({gv, blk, nom, got}), "xlate");
  end
  always @(posedge clk) if (++cyc_n == 3000) begin
    failures++;
    results;
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    reset_n = 0; cyc = 0; stb = 0; we = 0; rv = 0; rl = 0; rd = 0;
    adr = 0; sel = 4'hF; di = 0; ra = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int t = 2; t < 7; t++) begin
      rq.push_back(32'h0);
      wb(0, 8'(RTAM_IDX_TARGET_2 + t - 2), $random(seed));
    end
    $display("test reset values done");
    for (int t = 2; t < 7; t++) begin
      tv[t] = (t == 4) ? 7'h00 : 7'($random(seed)) | 7'h01;
      wb(1, 8'(RTAM_IDX_TARGET_2 + t - 2),
        {24'($random(seed)), tv[t], 1'b1});
      wb(1, 8'(RTAM_IDX_ALIAS_2 + t - 2), {24'h0, 7'h20 + 7'(t), 1'b0});
      rq.push_back({24'h0, tv[t], 1'b0});
      wb(0, 8'(RTAM_IDX_TARGET_2 + t - 2), 32'h0);
      rq.push_back({24'h0, 7'h20 + 7'(t), 1'b0});
      wb(0, 8'(RTAM_IDX_ALIAS_2 + t - 2), 32'h0);
    end
    wb(1, 8'h30, 32'hFF);
    rq.push_back(32'h0);
    wb(0, 8'h30, 32'h0);
    $display("test registers done");
    for (int t = 2; t < 7; t++) xl(1, 7'h20 + 7'(t), (t == 4) ?
      {3'b010, 10'h0} : {3'b100, 3'(t), tv[t]});
    // stop the request so the status word holds the forward to target 6
    @(posedge clk) rv <= 1'b0;
    rq.push_back(32'h0000_0086);
    wb(0, RTAM_IDX_STATUS, 32'h0);
    xl(0, 7'h22, 13'h0);
    xl(1, 7'h7F, {3'b001, 10'h0});
    xl(1, 7'h00, {3'b001, 10'h0});
    @(posedge clk) rv <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test translation done");
    results;
  end
endmodule : remote_target_address_map_test
